// *** shared/uart_status_pkg.sv ***
/*
  Constants and carrier types for the serial status and rate block.
  Assumes a host parallel byte bus with a 3-bit register address.
*/
package uart_status_pkg;
  localparam logic [2:0] addr_divisor_low = 3'h0;
  localparam logic [2:0] addr_divisor_high = 3'h1;
  localparam logic [2:0] addr_line_status = 3'h5;
  localparam logic [2:0] addr_modem_status = 3'h6;
  localparam logic [2:0] addr_spare_byte = 3'h7;
  localparam int line_ready_bit = 0;
  localparam int line_overrun_bit = 1;
  localparam int line_parity_bit = 2;
  localparam int line_stop_bit = 3;
  localparam int line_break_bit = 4;
  localparam int line_hold_bit = 5;
  localparam int line_idle_bit = 6;
  localparam logic [7:0] line_status_reset_value = 8'h60;
  localparam logic [7:0] modem_status_reset_value = 8'h00;
  localparam logic [7:0] spare_reset_value = 8'h00;
  localparam logic [15:0] divisor_reset_value = 16'h0000;
  localparam logic [1:0] rls_int_id = 2'h3;

  typedef struct packed {
    logic rd_stb;
    logic wr_stb;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic char_done;
    logic parity_bad;
    logic stop_bad;
    logic break_det;
    logic hold_to_shift;
    logic hold_full;
    logic shift_busy;
    logic rx_buf_read;
  } serial_event_type;

  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_type;

  typedef struct packed {
    logic loop;
    logic aux_output_two;
    logic aux_output_one;
    logic rts;
    logic dtr;
  } modem_ctrl_type;
endpackage : uart_status_pkg

// *** logic/uart_status_and_baud_generator.sv ***
/*
  Line status, modem status, spare byte, divisor latches and baud counter.
  Assumes single-cycle read/write strobes synchronous to core_clk_i and
  receiver/transmitter events delivered as one-cycle pulses or levels.
*/
//
// Overview of operation
// - receive ready sets on char, clears on buffer read
// - overrun sets on unread char, clears on read
// - parity fault sets, clears on status read
// - stop bit fault sets, clears on status read
// - break seen sets, clears on status read
// - error flags raise line status interrupt request
// - hold empty sets on transfer, clears on write
// - hold empty with enable raises interrupt request
// - all idle when hold and shift empty; D7 zero
// - line status read-only; host should not write
// - modem status read-only, change bits interrupt, read clears
// - change bits for cts, dsr, dcd toggles
// - ring edge bit on off-to-on transition
// - upper modem bits are inverted modem inputs
// - loop mode maps control bits into status
// - spare byte stores data, no other effect
// - divisor access selects low/high divisor bytes
// - divide clock by 1..65535 for 16x tick
// - divisor write reloads baud counter at once
// - divisor access bit gates divisor addressing
// - line status interrupt highest, code 110
`timescale 1ns/10ps
`default_nettype none

module uart_status_and_baud_generator (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire uart_status_pkg::host_req_type host_req_i,
  input wire logic divisor_access_sel_i,
  input wire uart_status_pkg::serial_event_type serial_event_i,
  input wire uart_status_pkg::modem_in_type modem_in_i,
  input wire uart_status_pkg::modem_ctrl_type modem_ctrl_reg_i,
  input wire logic hold_int_enable_i,
  input wire logic line_int_enable_i,
  input wire logic modem_int_enable_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic line_status_int_o,
  output logic hold_empty_int_o,
  output logic modem_status_int_o,
  output logic [1:0] line_int_id_o,
  output logic baud_tick_o,
  output logic [15:0] divisor_o
);
  import uart_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic rd_line;
  logic rd_modem;
  logic wr_low;
  logic wr_high;
  logic wr_spare;
  logic rx_ready_reg;
  logic overrun_reg;
  logic parity_fault_reg;
  logic stop_bit_fault_reg;
  logic line_break_seen_reg;
  logic tx_hold_empty_reg;
  logic tx_all_idle;
  logic [7:0] line_status_reg;
  logic [3:0] modem_changed_reg;
  logic [3:0] modem_level;
  logic [3:0] modem_level_reg;
  logic [7:0] modem_status_reg;
  logic [7:0] spare_byte_reg;
  logic [7:0] divisor_low_reg;
  logic [7:0] divisor_high;
  logic [15:0] divisor_next;
  logic [15:0] baud_count_reg;
  logic [7:0] rdata_next;

  assign rd_line = host_req_i.rd_stb && host_req_i.addr == addr_line_status;
  assign rd_modem = host_req_i.rd_stb && host_req_i.addr == addr_modem_status;
  // line status writes are factory-test only; deliberately ignored
  assign wr_low = host_req_i.wr_stb && divisor_access_sel_i &&
                  host_req_i.addr == addr_divisor_low;
  assign wr_high = host_req_i.wr_stb && divisor_access_sel_i &&
                   host_req_i.addr == addr_divisor_high;
  assign wr_spare = host_req_i.wr_stb && host_req_i.addr == addr_spare_byte;

  ////////////////////////////////////////////////////////////////////////
  // line status flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_ready_reg <= 1'b0;
    end else if (serial_event_i.char_done) begin
      rx_ready_reg <= 1'b1;
    end else if (serial_event_i.rx_buf_read) begin
      rx_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overrun_reg <= 1'b0;
      parity_fault_reg <= 1'b0;
      stop_bit_fault_reg <= 1'b0;
      line_break_seen_reg <= 1'b0;
    end else begin
      // overrun: new char while previous still unread
      overrun_reg <= (serial_event_i.char_done && rx_ready_reg &&
                      !serial_event_i.rx_buf_read) ||
                     (overrun_reg && !rd_line);
      parity_fault_reg <= serial_event_i.parity_bad ||
                          (parity_fault_reg && !rd_line);
      stop_bit_fault_reg <= serial_event_i.stop_bad ||
                            (stop_bit_fault_reg && !rd_line);
      line_break_seen_reg <= serial_event_i.break_det ||
                             (line_break_seen_reg && !rd_line);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_hold_empty_reg <= 1'b1;
    end else if (serial_event_i.hold_to_shift) begin
      tx_hold_empty_reg <= 1'b1;
    end else if (host_req_i.wr_stb && !divisor_access_sel_i &&
                 host_req_i.addr == addr_divisor_low) begin
      tx_hold_empty_reg <= 1'b0;
    end
  end

  assign tx_all_idle = !serial_event_i.hold_full &&
                       !serial_event_i.shift_busy;

  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[line_ready_bit] = rx_ready_reg;
    line_status_reg[line_overrun_bit] = overrun_reg;
    line_status_reg[line_parity_bit] = parity_fault_reg;
    line_status_reg[line_stop_bit] = stop_bit_fault_reg;
    line_status_reg[line_break_bit] = line_break_seen_reg;
    line_status_reg[line_hold_bit] = tx_hold_empty_reg;
    line_status_reg[line_idle_bit] = tx_all_idle;
  end

  assign line_status_int_o = line_int_enable_i &&
                             (|line_status_reg[4:1]);
  assign line_int_id_o = line_status_int_o ? rls_int_id : 2'h0;
  assign hold_empty_int_o = tx_hold_empty_reg && hold_int_enable_i;

  ////////////////////////////////////////////////////////////////////////
  // modem levels, active high; loop takes them from control bits
  always_comb begin
    if (modem_ctrl_reg_i.loop) begin
      modem_level = {modem_ctrl_reg_i.aux_output_two,
                     modem_ctrl_reg_i.aux_output_one,
                     modem_ctrl_reg_i.dtr,
                     modem_ctrl_reg_i.rts};
    end else begin
      modem_level = ~{modem_in_i.dcd_n, modem_in_i.ri_n,
                      modem_in_i.dsr_n, modem_in_i.cts_n};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      modem_level_reg <= 4'h0;
    end else begin
      modem_level_reg <= modem_level;
    end
  end

  // bit 2 is the ring edge, others any toggle; set beats read-clear
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_delta
      logic change;
      if (g == 2) begin : g_ring
        assign change = modem_level[g] && !modem_level_reg[g];
      end else begin : g_toggle
        assign change = modem_level[g] ^ modem_level_reg[g];
      end
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          modem_changed_reg[g] <= 1'b0;
        end else begin
          modem_changed_reg[g] <= change ||
                                  (modem_changed_reg[g] && !rd_modem);
        end
      end
    end
  endgenerate

  assign modem_status_reg = {modem_level_reg, modem_changed_reg};
  assign modem_status_int_o = modem_int_enable_i &&
                              (|modem_changed_reg);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spare_byte_reg <= spare_reset_value;
    end else if (wr_spare) begin
      spare_byte_reg <= host_req_i.wdata;
    end
  end

  // either byte write alone sets the rate, the other byte keeping its value
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      divisor_low_reg <= divisor_reset_value[7:0];
      divisor_high <= divisor_reset_value[15:8];
    end else begin
      if (wr_low) begin
        divisor_low_reg <= host_req_i.wdata;
      end
      if (wr_high) begin
        divisor_high <= host_req_i.wdata;
      end
    end
  end

  always_comb begin
    divisor_next = {divisor_high, divisor_low_reg};
    if (wr_low) begin
      divisor_next[7:0] = host_req_i.wdata;
    end
    if (wr_high) begin
      divisor_next[15:8] = host_req_i.wdata;
    end
  end
  assign divisor_o = {divisor_high, divisor_low_reg};

  ////////////////////////////////////////////////////////////////////////
  // divisor zero is illegal; counter then stays parked with no tick
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_count_reg <= divisor_reset_value;
      baud_tick_o <= 1'b0;
    end else if (wr_low || wr_high) begin
      baud_count_reg <= divisor_next;
      baud_tick_o <= 1'b0;
    end else if (divisor_o == 16'h0000) begin
      baud_count_reg <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else if (baud_count_reg <= 16'h0001) begin
      baud_count_reg <= divisor_o;
      baud_tick_o <= 1'b1;
    end else begin
      baud_count_reg <= baud_count_reg - 16'h0001;
      baud_tick_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads return zero
  always_comb begin
    case (host_req_i.addr)
      addr_divisor_low: rdata_next = divisor_access_sel_i ?
                                     divisor_low_reg : 8'h00;
      addr_divisor_high: rdata_next = divisor_access_sel_i ?
                                      divisor_high : 8'h00;
      addr_line_status: rdata_next = line_status_reg;
      addr_modem_status: rdata_next = modem_status_reg;
      addr_spare_byte: rdata_next = spare_byte_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= host_req_i.rd_stb;
      if (host_req_i.rd_stb) begin
        rdata_o <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_ready_set;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      serial_event_i.char_done |=> rx_ready_reg;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready not set");

  property p_overrun;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      serial_event_i.char_done && rx_ready_reg &&
      !serial_event_i.rx_buf_read |=> overrun_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_err_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      rd_line && !serial_event_i.parity_bad && !serial_event_i.stop_bad
      |=> !parity_fault_reg && !stop_bit_fault_reg;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("err kept");

  property p_line_int;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      serial_event_i.break_det && line_int_enable_i ##1 line_int_enable_i
      |-> line_status_int_o && line_int_id_o == 2'h3;
  endproperty
  a_line_int: assert property (p_line_int) else $error("no line int");

  property p_hold_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      host_req_i.wr_stb && !divisor_access_sel_i &&
      host_req_i.addr == 3'h0 && !serial_event_i.hold_to_shift
      |=> !tx_hold_empty_reg;
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("hold flag");

  property p_ring;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(modem_level_reg[2]) && !rd_modem ##1 !rd_modem
      |-> $stable(modem_changed_reg[2]);
  endproperty
  a_ring: assert property (p_ring) else $error("ring on fall");

  property p_reload;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_high |=> baud_count_reg == $past(divisor_next);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_tick_div1;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      divisor_o == 16'h0001 && !wr_low && !wr_high && baud_tick_o
      ##1 divisor_o == 16'h0001 && !wr_low && !wr_high |=> baud_tick_o;
  endproperty
  a_tick_div1: assert property (p_tick_div1) else $error("div1 tick");

  c_overrun: cover property (@(posedge core_clk_i) overrun_reg);
  c_tick: cover property (@(posedge core_clk_i) baud_tick_o);
  c_loop_delta: cover property (@(posedge core_clk_i)
    modem_ctrl_reg_i.loop && modem_status_int_o);
endmodule : uart_status_and_baud_generator

`default_nettype wire

// *** verif/modem_line_model.sv ***
/*
  Behavioural modem on the far side: drives the four active-low status
  lines. Assumes the bench asks for line states by an asserted-high vector.
*/
`timescale 1ns/10ps
`default_nettype none

module modem_line_model (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] assert_i,
  output uart_status_pkg::modem_in_type lines_o
);
  import uart_status_pkg::*;

  // lines idle inactive (high) out of reset, change one edge after request
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lines_o <= 4'hF;
    end else begin
      lines_o <= ~assert_i;
    end
  end
endmodule : modem_line_model

`default_nettype wire

// *** verif/uart_status_and_baud_generator_tb.sv ***
/*
  Self-checking bench for the status and rate block.
  Assumes single-cycle strobes driven at the falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module uart_status_and_baud_generator_tb;
  import uart_status_pkg::*;

  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  host_req_type req = '0;
  logic sel = 1'b0;
  serial_event_type ev = '0;
  modem_in_type lines;
  modem_ctrl_type mc = '0;
  logic [3:0] want = 4'h0;
  logic [2:0] int_en = 3'b111;
  logic [7:0] rdata;
  logic valid, ls_int, he_int, ms_int, tick;
  logic [1:0] id;
  logic [15:0] div;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int c;

  uart_status_and_baud_generator dut_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .host_req_i(req),
    .divisor_access_sel_i(sel), .serial_event_i(ev),
    .modem_in_i(lines), .modem_ctrl_reg_i(mc),
    .hold_int_enable_i(int_en[2]), .line_int_enable_i(int_en[1]),
    .modem_int_enable_i(int_en[0]), .rdata_o(rdata), .rdata_valid_o(valid),
    .line_status_int_o(ls_int), .hold_empty_int_o(he_int),
    .modem_status_int_o(ms_int), .line_int_id_o(id),
    .baud_tick_o(tick), .divisor_o(div));

  modem_line_model modem_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .assert_i(want), .lines_o(lines));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // hang guard, well above the ~650 cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req.wr_stb = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge core_clk_i);
    req.wr_stb = 1'b0;
    @(negedge core_clk_i);
  endtask : wr

  // read data and valid stand in the cycle after the strobe; one idle
  // cycle after each access keeps back-to-back calls from re-driving
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    req.rd_stb = 1'b1;
    req.addr = a;
    @(negedge core_clk_i);
    req.rd_stb = 1'b0;
    `CHK({valid, rdata}, {1'b1, e})
    @(negedge core_clk_i);
  endtask : rd

  // pulse fields last one cycle, the two level fields are kept
  task automatic pulse(input logic [7:0] m);
    ev = ev | m;
    @(negedge core_clk_i);
    ev = ev & 8'h06;
  endtask : pulse

  // cycles until the next tick, bounded
  task automatic gap(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 70000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask : gap

  task automatic period(input int n);
    gap(c);
    @(negedge core_clk_i);
    gap(c);
    `CHK(c + 1, n)
  endtask : period

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    rd(addr_line_status, line_status_reset_value);
    rd(addr_modem_status, 8'h00);
    $display("test reset done");

    pulse(8'h80);
    rd(addr_line_status, 8'h61);
    pulse(8'h80);
    rd(addr_line_status, 8'h63);
    rd(addr_line_status, 8'h61);
    pulse(8'h01);
    rd(addr_line_status, 8'h60);
    for (int i = 0; i < 3; i++) begin
      pulse(8'h40 >> i);
      `CHK({ls_int, id}, {1'b1, rls_int_id})
      rd(addr_line_status, 8'h60 | (8'h04 << i));
      `CHK(ls_int, 1'b0)
    end
    wr(addr_line_status, 8'hFF);
    rd(addr_line_status, 8'h60);
    $display("test receive flags done");

    ev.hold_full = 1'b1;
    wr(3'h0, 8'h41);
    rd(addr_line_status, 8'h00);
    // hold moves to shift: one-cycle transfer, then shift alone busy
    ev = 8'h0A;
    @(negedge core_clk_i);
    ev = 8'h02;
    rd(addr_line_status, 8'h20);
    `CHK(he_int, 1'b1)
    int_en = 3'b000;
    @(negedge core_clk_i);
    `CHK(he_int, 1'b0)
    int_en = 3'b111;
    ev = 8'h00;
    rd(addr_line_status, 8'h60);
    $display("test transmit flags done");

    want = 4'b0001;
    repeat (4) @(negedge core_clk_i);
    `CHK(ms_int, 1'b1)
    int_en = 3'b110;
    @(negedge core_clk_i);
    `CHK(ms_int, 1'b0)
    int_en = 3'b111;
    rd(addr_modem_status, 8'h11);
    rd(addr_modem_status, 8'h10);
    `CHK(ms_int, 1'b0)
    want = 4'b0101;
    repeat (4) @(negedge core_clk_i);
    rd(addr_modem_status, 8'h54);
    want = 4'b0001;
    repeat (4) @(negedge core_clk_i);
    rd(addr_modem_status, 8'h10);
    want = 4'b1111;
    repeat (4) @(negedge core_clk_i);
    wr(addr_modem_status, 8'h00);
    rd(addr_modem_status, 8'hFE);
    rd(addr_modem_status, 8'hF0);
    // loop: cts<-rts, dsr<-dtr, ri<-aux one, dcd<-aux two
    mc = 5'b11010;
    repeat (4) @(negedge core_clk_i);
    rd(addr_modem_status, 8'h92);
    mc = 5'b00000;
    repeat (4) @(negedge core_clk_i);
    rd(addr_modem_status, 8'hF6);
    $display("test modem status done");

    wr(addr_spare_byte, 8'hA5);
    rd(addr_spare_byte, 8'hA5);
    wr(addr_spare_byte, 8'h5A);
    rd(addr_spare_byte, 8'h5A);
    rd(addr_line_status, 8'h60);
    rd(3'h2, 8'h00);
    $display("test spare byte done");

    sel = 1'b1;
    wr(addr_divisor_low, 8'h03);
    wr(addr_divisor_high, 8'h00);
    rd(addr_divisor_low, 8'h03);
    rd(addr_divisor_high, 8'h00);
    `CHK(div, 16'h0003)
    period(3);
    wr(addr_divisor_low, 8'h01);
    period(1);
    wr(addr_divisor_low, 8'hFF);
    wr(addr_divisor_high, 8'hFF);
    wr(addr_divisor_high, 8'h00);
    gap(c);
    `CHK(c <= 257, 1'b1)
    `CHK(div, 16'h00FF)
    period(255);
    // zero divisor parks the counter: no tick at all
    wr(addr_divisor_low, 8'h00);
    repeat (8) begin
      @(negedge core_clk_i);
      `CHK(tick, 1'b0)
    end
    sel = 1'b0;
    $display("test baud done");
    results();
  end
endmodule : uart_status_and_baud_generator_tb

`default_nettype wire
